/* src/cps_regs.svh */
// How it works
// - Three exclusive modes: charge, boost, high impedance
// - High impedance disables charge and boost entirely
// - Unconfigured device charges using register reset values
// - Unconfigured input limit follows otg_level: 100/500 mA
// - Safety timer and watchdog stay permanently disabled
// - No battery presence check at power-up
// - Input overvoltage: converter off, fault bits, pulse
// - Input overvoltage exit clears fault, resumes charging
// - Input power-on applies current sink to test adaptor
// - Input above minimum 30 ms: adaptor good, charge
// - Input dips: sink off, pulse, fault code 011
// - After bad adaptor, wait retry interval, retest
// - Sleep when input below battery plus offset
// - Sleep turns off blocking switch and converter
// - Input sag to dpm threshold reduces charge current
// - Weak-source flag set while dpm limits current
// - Battery overvoltage: converter off, fault bits, pulse
// - Battery overvoltage exit clears fault, resumes charging
// - Unconfigured after power-on until a host register write
// - Host mode input limit from control register bits
`ifndef CPS_REGS_SVH
`define CPS_REGS_SVH

// Register indices; byte address is four times the index
`define CPS_IDX_STAT     6'h00
`define CPS_IDX_CTRL     6'h01
`define CPS_IDX_SPEC     6'h05

// Status register fields
`define CPS_FAULT_MSB    2
`define CPS_FAULT_LSB    0
`define CPS_HOST_BIT     3
`define CPS_STATE_MSB    5
`define CPS_STATE_LSB    4
`define CPS_SLEEP_BIT    6
`define CPS_TIMER_BIT    7

// Control register fields and reset value
`define CPS_MODE_MSB     1
`define CPS_MODE_LSB     0
`define CPS_ILIM_MSB     7
`define CPS_ILIM_LSB     6
`define CPS_CTRL_RST     8'h00

// Special charger register field
`define CPS_WEAK_BIT     4

// Fault codes
`define CPS_FLT_NONE     3'h0
`define CPS_FLT_VOVP     3'h1
`define CPS_FLT_BAD      3'h3
`define CPS_FLT_BOVP     3'h4

// Mode field codes
`define CPS_MODE_CHG     2'h0
`define CPS_MODE_BOOST   2'h1
`define CPS_MODE_HIZ     2'h2

// Input limit codes: 100 mA, 500 mA
`define CPS_ILIM_100     2'h0
`define CPS_ILIM_500     2'h1

// Comparator input positions
`define CPS_IN_VOVP      0
`define CPS_IN_VOK       1
`define CPS_IN_SLP       2
`define CPS_IN_DPM       3
`define CPS_IN_BOVP      4
`define CPS_IN_VPRES     5
`define CPS_NIN          6

// Timing
`define CPS_CLK_KHZ      20000
`define CPS_ADAPT_MS     30
`define CPS_RETRY_MS     1000
`define CPS_PULSE_US     128

`endif

/* src/cps_pkg.sv */
// Shared types for the supervisor
package cps_pkg;
	// Adaptor qualification and run states
	typedef enum logic [1:0] {ST_IDLE, ST_TEST, ST_RETRY, ST_RUN} cps_state_t;
	// Operating modes
	typedef enum logic [1:0] {MODE_CHARGE, MODE_BOOST, MODE_HIZ} cps_mode_t;
endpackage : cps_pkg

/* src/cps_fault_if.sv */
`timescale 1ns/100ps
// Fault event carrier between supervisor and pulse generator
interface cps_fault_if;
	logic evt;    // One-cycle fault event
	logic busy;   // Pulse in progress
	logic pulse;  // Fault pulse level
	modport src (output evt, input busy, input pulse);
	modport gen (input evt, output busy, output pulse);
endinterface : cps_fault_if

/* src/cps_pulse.sv */
`timescale 1ns/100ps
`include "cps_regs.svh"
// Fixed-length fault pulse generator
module cps_pulse #(
	parameter int PULSE_CYC = `CPS_PULSE_US * `CPS_CLK_KHZ / 1000
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic ce,
	// Fault events in, pulse out
	cps_fault_if.gen  f
);
	logic [15:0] cnt_r;    // Cycles elapsed in pulse
	logic        pulse_r;  // Pulse level
	wire         last = (cnt_r == 16'(PULSE_CYC - 1));

	assign f.pulse = pulse_r;
	assign f.busy  = pulse_r;

	// Events during a pulse are ignored so the pulse keeps its length
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pulse_r <= 1'b0;
			cnt_r   <= 16'h0000;
		end
		else if (ce)
		begin
			if (!pulse_r)
			begin
				pulse_r <= f.evt;
				cnt_r   <= 16'h0000;
			end
			else
			begin
				pulse_r <= !last;
				cnt_r   <= cnt_r + 16'h0001;
			end
		end
	end

	// Pulse runs on until its count is spent
	property p_pulse_hold;
		@(posedge core_clk) disable iff (!rstn)
		(pulse_r && !last) |=> pulse_r;
	endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("fault pulse ended early");

	property p_pulse_len;
		@(posedge core_clk) disable iff (!rstn)
		pulse_r |-> (cnt_r < 16'(PULSE_CYC));
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("fault pulse too long");
endmodule : cps_pulse

/* src/cps_top.sv */
`timescale 1ns/100ps
`include "cps_regs.svh"
// Charger protection supervisor
module cps_top #(
	parameter int ADAPT_CYC = `CPS_ADAPT_MS * `CPS_CLK_KHZ,   // Adaptor good time
	parameter int RETRY_CYC = `CPS_RETRY_MS * `CPS_CLK_KHZ,   // Bad adaptor retry delay
	parameter int PULSE_CYC = `CPS_PULSE_US * `CPS_CLK_KHZ / 1000,
	parameter int CNT_W     = 25                              // Qualification counter width
) (
	// Clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Analog comparator results
	input  wire logic        vbus_ovp,
	input  wire logic        vbus_ok,
	input  wire logic        vbus_below_sleep,
	input  wire logic        vbus_dpm,
	input  wire logic        bat_ovp,
	input  wire logic        vbus_present,
	// Pin levels
	input  wire logic        otg_level,
	// Power stage controls
	output logic             charge_en,
	output logic             boost_en,
	output logic             reverse_block_switch,
	output logic             sink_en,
	output logic             dpm_limit,
	output logic             hiz_active,
	output logic [1:0]       ilim_sel,
	// Status
	output logic             status_pin
);

	// Synchroniser stages
	logic [`CPS_NIN-1:0] meta_r;   // First stage, read only by second
	logic [`CPS_NIN-1:0] sync_r;   // Settled comparator levels
	logic [`CPS_NIN-1:0] prev_r;   // Previous settled levels for edges

	// Control state
	cps_pkg::cps_state_t state_r;  // Qualification state
	cps_pkg::cps_state_t state_nxt;
	logic [CNT_W-1:0]    cnt_r;    // Test and retry timer
	logic [CNT_W-1:0]    cnt_nxt;
	logic                host_r;   // Host has written a register
	logic [7:0]          ctrl_r;   // Mode and input limit
	logic                bad_r;    // Last adaptor test failed
	logic [31:0]         prdata_r; // Read data captured at setup

	// Comparator two-stage synchroniser; the first stage feeds nothing else
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
		end
		else if (ce)
		begin
			meta_r <= {vbus_present, bat_ovp, vbus_dpm, vbus_below_sleep, vbus_ok, vbus_ovp};
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Settled levels and their edges
	wire vovp_s  = sync_r[`CPS_IN_VOVP];
	wire vok_s   = sync_r[`CPS_IN_VOK];
	wire slp_s   = sync_r[`CPS_IN_SLP];
	wire dpm_s   = sync_r[`CPS_IN_DPM];
	wire bovp_s  = sync_r[`CPS_IN_BOVP];
	wire vpres_s = sync_r[`CPS_IN_VPRES];
	wire vovp_rise = vovp_s && !prev_r[`CPS_IN_VOVP];
	wire bovp_rise = bovp_s && !prev_r[`CPS_IN_BOVP];

	// Timer terminal counts
	wire test_done  = (cnt_r == CNT_W'(ADAPT_CYC - 1));
	wire retry_done = (cnt_r == CNT_W'(RETRY_CYC - 1));

	// Adaptor failure: input sagged under the sink
	wire bad_evt = (state_r == cps_pkg::ST_TEST) && vpres_s && !vok_s;

	// APB decode
	wire [5:0] idx      = paddr[7:2];
	wire       aligned  = (paddr[1:0] == 2'h0);
	wire       hit_stat = aligned && (idx == `CPS_IDX_STAT);
	wire       hit_ctrl = aligned && (idx == `CPS_IDX_CTRL);
	wire       hit_spec = aligned && (idx == `CPS_IDX_SPEC);
	wire       mapped   = hit_stat || hit_ctrl || hit_spec;
	wire       setup    = psel && !penable;
	wire       access   = psel && penable;
	wire       wr_ok    = access && pwrite && mapped;
	// Status is read only, so only the control register stores writes
	wire       wr_ctrl  = wr_ok && hit_ctrl;
	// An illegal mode code is refused, the previous mode is kept
	wire       mode_legal = (pwdata[`CPS_MODE_MSB:`CPS_MODE_LSB] != 2'h3);

	// Operating mode decode; exactly one mode is ever active
	wire [1:0] mode_fld = ctrl_r[`CPS_MODE_MSB:`CPS_MODE_LSB];
	cps_pkg::cps_mode_t mode;
	assign mode = (mode_fld == `CPS_MODE_BOOST) ? cps_pkg::MODE_BOOST :
	              (mode_fld == `CPS_MODE_HIZ)   ? cps_pkg::MODE_HIZ   :
	                                              cps_pkg::MODE_CHARGE;

	// Sleep: input above minimum but under battery plus offset
	wire sleep = vok_s && slp_s;
	// Either overvoltage stops the converter until its exit level
	wire ovp_any = vovp_s || bovp_s;
	// Charging is allowed once the adaptor passed and no fault or sleep holds
	wire run_ok  = (state_r == cps_pkg::ST_RUN) && !ovp_any && !sleep;

	// Fault code: overvoltage while present, else a stuck bad-adaptor flag
	wire [2:0] fault_code = vovp_s ? `CPS_FLT_VOVP :
	                        bovp_s ? `CPS_FLT_BOVP :
	                        bad_r  ? `CPS_FLT_BAD  : `CPS_FLT_NONE;

	// Power stage controls
	wire chg_w  = run_ok && (mode == cps_pkg::MODE_CHARGE);
	// Boost draws from the battery, so it needs no qualified adaptor
	wire bst_w  = (mode == cps_pkg::MODE_BOOST) && !ovp_any && !vpres_s;
	assign charge_en            = chg_w;
	assign boost_en             = bst_w;
	// Blocking switch opens in sleep so the battery cannot feed the input
	assign reverse_block_switch = (chg_w || bst_w) && !sleep;
	assign sink_en              = (state_r == cps_pkg::ST_TEST) && (mode != cps_pkg::MODE_HIZ);
	assign dpm_limit            = chg_w && dpm_s;
	assign hiz_active           = (mode == cps_pkg::MODE_HIZ);
	// Input limit follows the pin until a host takes over
	assign ilim_sel = host_r ? ctrl_r[`CPS_ILIM_MSB:`CPS_ILIM_LSB] :
	                  (otg_level ? `CPS_ILIM_500 : `CPS_ILIM_100);

	// Read data mux; the timer status bit is hard zero since no timer exists
	logic [7:0] stat_v;
	logic [7:0] spec_v;
	assign stat_v = {1'b0, sleep, state_r, host_r, fault_code};
	assign spec_v = {3'h0, dpm_limit, 4'h0};
	wire [31:0] rd_mux = hit_stat ? {24'h000000, stat_v} :
	                     hit_ctrl ? {24'h000000, ctrl_r} :
	                     hit_spec ? {24'h000000, spec_v} : 32'h00000000;

	// APB answers in the access cycle with no wait states
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata  = prdata_r;

	// Fault pulse generator
	cps_fault_if fif ();
	assign fif.evt = ce && (vovp_rise || bovp_rise || bad_evt);
	assign status_pin = fif.pulse;

	cps_pulse #(
		.PULSE_CYC (PULSE_CYC)
	) u_pulse (
		.core_clk (core_clk),
		.rstn     (rstn),
		.ce       (ce),
		.f        (fif)
	);

	// Qualification sequence next state
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + CNT_W'(1);
		unique case (state_r)
			cps_pkg::ST_IDLE:
			begin
				// Straight to the adaptor test; no battery check first
				cnt_nxt = '0;
				if (vpres_s)
					state_nxt = cps_pkg::ST_TEST;
			end
			cps_pkg::ST_TEST:
			begin
				if (!vpres_s)
					state_nxt = cps_pkg::ST_IDLE;
				else if (!vok_s)
				begin
					state_nxt = cps_pkg::ST_RETRY;
					cnt_nxt   = '0;
				end
				else if (test_done)
				begin
					state_nxt = cps_pkg::ST_RUN;
					cnt_nxt   = '0;
				end
			end
			cps_pkg::ST_RETRY:
			begin
				if (!vpres_s)
					state_nxt = cps_pkg::ST_IDLE;
				else if (retry_done)
				begin
					state_nxt = cps_pkg::ST_TEST;
					cnt_nxt   = '0;
				end
			end
			cps_pkg::ST_RUN:
			begin
				// Charging resumes by itself once faults clear
				cnt_nxt = '0;
				if (!vpres_s)
					state_nxt = cps_pkg::ST_IDLE;
			end
		endcase
	end

	// State and timer
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= cps_pkg::ST_IDLE;
			cnt_r   <= '0;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// Bad adaptor flag: set on failure, cleared when a later test passes
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			bad_r <= 1'b0;
		else if (ce)
		begin
			if (bad_evt)
				bad_r <= 1'b1;
			else if (state_r == cps_pkg::ST_TEST && test_done && vok_s)
				bad_r <= 1'b0;
		end
	end

	// Host mode latch: only power-on reset returns to unconfigured
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			host_r <= 1'b0;
		else if (ce && wr_ok)
			host_r <= 1'b1;
	end

	// Control register holds reset values until the host writes it
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			ctrl_r <= `CPS_CTRL_RST;
		else if (ce && wr_ctrl && mode_legal)
			ctrl_r <= pwdata[7:0];
	end

	// Read data captured in the setup cycle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			prdata_r <= 32'h00000000;
		else if (ce && setup && !pwrite)
			prdata_r <= rd_mux;
	end

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_test_pass;
		ce && state_r == cps_pkg::ST_TEST && vpres_s && vok_s && test_done;
	endsequence
	sequence s_test_fail;
		ce && state_r == cps_pkg::ST_TEST && vpres_s && !vok_s;
	endsequence

	property p_hiz_off;
		hiz_active |-> !charge_en && !boost_en && !sink_en;
	endproperty
	a_hiz_off: assert property (p_hiz_off) else $error("converter active in high impedance");

	property p_ilim_pin;
		!host_r |-> ilim_sel == (otg_level ? `CPS_ILIM_500 : `CPS_ILIM_100);
	endproperty
	a_ilim_pin: assert property (p_ilim_pin) else $error("default limit not from pin");

	property p_ilim_host;
		host_r |-> ilim_sel == ctrl_r[`CPS_ILIM_MSB:`CPS_ILIM_LSB];
	endproperty
	a_ilim_host: assert property (p_ilim_host) else $error("host limit not from register");

	property p_vovp;
		vovp_s |-> !charge_en && !boost_en && fault_code == `CPS_FLT_VOVP;
	endproperty
	a_vovp: assert property (p_vovp) else $error("input overvoltage not handled");

	property p_bovp;
		bovp_s && !vovp_s |-> !charge_en && !boost_en && fault_code == `CPS_FLT_BOVP;
	endproperty
	a_bovp: assert property (p_bovp) else $error("battery overvoltage not handled");

	property p_sleep;
		sleep |-> !reverse_block_switch && !charge_en;
	endproperty
	a_sleep: assert property (p_sleep) else $error("switch on during sleep");

	property p_pass;
		s_test_pass |=> state_r == cps_pkg::ST_RUN && !sink_en;
	endproperty
	a_pass: assert property (p_pass) else $error("good adaptor not accepted");

	property p_fail;
		s_test_fail |=> state_r == cps_pkg::ST_RETRY && !sink_en && bad_r && status_pin;
	endproperty
	a_fail: assert property (p_fail) else $error("bad adaptor not flagged");

	property p_weak;
		charge_en && dpm_s |-> dpm_limit && spec_v[`CPS_WEAK_BIT];
	endproperty
	a_weak: assert property (p_weak) else $error("weak source flag missing");

	property p_no_timer;
		stat_v[`CPS_TIMER_BIT] == 1'b0;
	endproperty
	a_no_timer: assert property (p_no_timer) else $error("timer reported active");
endmodule : cps_top

/* verification/cps_supply_model.sv */
`timescale 1ns/100ps
// Input supply behind the bus comparators; it only drives comparator levels
module cps_supply_model (
	// Clock
	input  wire logic core_clk,
	// Comparator levels seen by the supervisor
	output logic      vbus_present,
	output logic      vbus_ok,
	output logic      vbus_below_sleep,
	output logic      vbus_dpm,
	output logic      vbus_ovp
);
	// Detached supply: every comparator reads low
	initial
	begin
		vbus_present     = 1'b0;
		vbus_ok          = 1'b0;
		vbus_below_sleep = 1'b0;
		vbus_dpm         = 1'b0;
		vbus_ovp         = 1'b0;
	end

	// New levels land just after a rising edge, never on it
	task automatic drive(input logic pres, input logic ok, input logic slp, input logic dpm, input logic ovp);
		@(posedge core_clk);
		vbus_present     <= pres;
		vbus_ok          <= ok;
		vbus_below_sleep <= slp;
		vbus_dpm         <= dpm;
		vbus_ovp         <= ovp;
	endtask : drive
endmodule : cps_supply_model

/* verification/cps_top_tb.sv */
`timescale 1ns/100ps
`include "cps_regs.svh"
// Self-checking bench for the supervisor, short counts
module cps_top_tb;
	localparam int AC = 20;                         // Shortened adaptor time
	localparam int RC = 30;                         // Shortened retry delay
	localparam int PC = 8;                          // Shortened pulse length
	localparam logic [7:0] A_STAT = 8'h00;
	localparam logic [7:0] A_CTRL = 8'h04;
	localparam logic [7:0] A_SPEC = 8'h14;
	logic core_clk = 1'b0, rstn = 1'b0, ce = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, bat_ovp = 1'b0, otg_level = 1'b0;
	logic vbus_ovp, vbus_ok, vbus_below_sleep, vbus_dpm, vbus_present;
	logic charge_en, boost_en, reverse_block_switch, sink_en, dpm_limit, hiz_active, status_pin;
	logic [1:0] ilim_sel;
	int miscompares = 0, num_checks = 0;
	logic [31:0] d;
	int n;

	// 20 MHz clock
	always #25 core_clk = ~core_clk;

	cps_supply_model i_sup (.core_clk(core_clk), .vbus_present(vbus_present), .vbus_ok(vbus_ok),
		.vbus_below_sleep(vbus_below_sleep), .vbus_dpm(vbus_dpm), .vbus_ovp(vbus_ovp));

	cps_top #(.ADAPT_CYC(AC), .RETRY_CYC(RC), .PULSE_CYC(PC), .CNT_W(25)) i_dut (
		.core_clk(core_clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.vbus_ovp(vbus_ovp), .vbus_ok(vbus_ok), .vbus_below_sleep(vbus_below_sleep), .vbus_dpm(vbus_dpm),
		.bat_ovp(bat_ovp), .vbus_present(vbus_present), .otg_level(otg_level), .charge_en(charge_en),
		.boost_en(boost_en), .reverse_block_switch(reverse_block_switch), .sink_en(sink_en),
		.dpm_limit(dpm_limit), .hiz_active(hiz_active), .ilim_sel(ilim_sel), .status_pin(status_pin));

	// Verdict in one place
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	// Compare and count
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; the request stands until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w, output logic [31:0] r,
		output logic err);
		int k;
		@(posedge core_clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= w;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			chk("apb wait", 32'h1, 32'h0);
			tally_and_finish();
		end
		r = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read one register
	task automatic rd(input logic [7:0] a);
		logic e;
		apb(1'b0, a, 32'h0, d, e);
	endtask : rd

	// Wait at falling edges until a flag reaches a level, bounded
	task automatic wait_lvl(input int s, input logic lv, input int lim);
		int k;
		k = 0;
		do
		begin
			@(negedge core_clk);
			k++;
		end
		while ((s == 0 ? sink_en : s == 1 ? charge_en : status_pin) !== lv && k < lim);
		n = k;
		if (k >= lim)
		begin
			chk("wait", 32'h1, 32'h0);
			tally_and_finish();
		end
	endtask : wait_lvl

	// Width of the next fault pulse
	task automatic pulse_len;
		wait_lvl(2, 1'b1, 10);
		wait_lvl(2, 1'b0, 100);
		chk("pulse width", PC, n);
	endtask : pulse_len

	// Reset state and default input limit
	task automatic t_reset;
		@(negedge core_clk);
		chk("ilim low", `CPS_ILIM_100, ilim_sel);
		@(posedge core_clk);
		otg_level <= 1'b1;
		@(negedge core_clk);
		chk("ilim high", `CPS_ILIM_500, ilim_sel);
		rd(A_STAT);
		chk("timer bit", 1'b0, d[`CPS_TIMER_BIT]);
		chk("host bit", 1'b0, d[`CPS_HOST_BIT]);
		rd(A_CTRL);
		chk("ctrl reset", `CPS_CTRL_RST, d);
		$display("test reset done");
	endtask : t_reset

	// Good adaptor: sink first, charging only after the full test time
	task automatic t_good;
		i_sup.drive(1, 1, 0, 0, 0);
		wait_lvl(0, 1'b1, 6);
		chk("no charge in test", 1'b0, charge_en);
		wait_lvl(1, 1'b1, AC + 6);
		// Sink seen one falling edge after its edge, so charge shows AC edges later
		chk("test time", AC, n);
		chk("reverse switch on", 1'b1, reverse_block_switch);
		rd(A_STAT);
		chk("run state", 2'h3, d[5:4]);
		$display("test good adaptor done");
	endtask : t_good

	// Weak source and sleep
	task automatic t_dpm_sleep;
		i_sup.drive(1, 1, 0, 1, 0);
		repeat (4) @(negedge core_clk);
		chk("dpm limit", 1'b1, dpm_limit);
		rd(A_SPEC);
		chk("weak bit", 1'b1, d[`CPS_WEAK_BIT]);
		i_sup.drive(1, 1, 1, 0, 0);
		repeat (4) @(negedge core_clk);
		chk("sleep charge", 1'b0, charge_en);
		chk("sleep switch", 1'b0, reverse_block_switch);
		rd(A_STAT);
		chk("sleep bit", 1'b1, d[`CPS_SLEEP_BIT]);
		i_sup.drive(1, 1, 0, 0, 0);
		wait_lvl(1, 1'b1, 6);
		$display("test dpm and sleep done");
	endtask : t_dpm_sleep

	// Overvoltage on both sides, overlapping events
	task automatic t_ovp;
		i_sup.drive(1, 1, 0, 0, 1);
		wait_lvl(1, 1'b0, 6);
		@(posedge core_clk);
		bat_ovp <= 1'b1;
		wait_lvl(2, 1'b0, 100);
		// Pulse rose at the edge just before counting began, so it ends one edge later
		chk("pulse width", PC + 1, n);
		repeat (8) @(negedge core_clk);
		chk("no second pulse", 1'b0, status_pin);
		rd(A_STAT);
		chk("vbus fault", `CPS_FLT_VOVP, d[2:0]);
		i_sup.drive(1, 1, 0, 0, 0);
		repeat (5) @(negedge core_clk);
		rd(A_STAT);
		chk("bat fault", `CPS_FLT_BOVP, d[2:0]);
		chk("bat ovp charge", 1'b0, charge_en);
		@(posedge core_clk);
		bat_ovp <= 1'b0;
		wait_lvl(1, 1'b1, 6);
		rd(A_STAT);
		chk("fault cleared", `CPS_FLT_NONE, d[2:0]);
		@(posedge core_clk);
		bat_ovp <= 1'b1;
		pulse_len();
		@(posedge core_clk);
		bat_ovp <= 1'b0;
		wait_lvl(1, 1'b1, 6);
		$display("test overvoltage done");
	endtask : t_ovp

	// Bad adaptor, fault code and retry
	task automatic t_bad;
		i_sup.drive(0, 0, 0, 0, 0);
		repeat (5) @(negedge core_clk);
		i_sup.drive(1, 1, 0, 0, 0);
		wait_lvl(0, 1'b1, 6);
		i_sup.drive(1, 0, 0, 0, 0);
		pulse_len();
		chk("sink off", 1'b0, sink_en);
		rd(A_STAT);
		chk("bad code", `CPS_FLT_BAD, d[2:0]);
		chk("retry state", 2'h2, d[5:4]);
		i_sup.drive(1, 1, 0, 0, 0);
		wait_lvl(0, 1'b1, RC + 10);
		chk("retry delay", 1, (n >= RC - PC - 12) ? 1 : 0);
		wait_lvl(1, 1'b1, AC + 6);
		$display("test bad adaptor done");
	endtask : t_bad

	// Host control: limit bits, modes, refused accesses
	task automatic t_host;
		logic e;
		apb(1'b1, A_CTRL, 32'h80, d, e);
		otg_level <= 1'b0;
		repeat (2) @(negedge core_clk);
		chk("host ilim", 2'h2, ilim_sel);
		rd(A_STAT);
		chk("host bit", 1'b1, d[`CPS_HOST_BIT]);
		apb(1'b1, A_CTRL, {30'h0, `CPS_MODE_HIZ}, d, e);
		@(negedge core_clk);
		chk("hiz", 3'b100, {hiz_active, charge_en, boost_en});
		apb(1'b1, A_CTRL, 32'h3, d, e);
		rd(A_CTRL);
		chk("mode 11 ignored", {30'h0, `CPS_MODE_HIZ}, d);
		apb(1'b0, 8'h08, 32'h0, d, e);
		chk("unmapped err", 1'b1, e);
		apb(1'b1, A_CTRL, {30'h0, `CPS_MODE_BOOST}, d, e);
		i_sup.drive(0, 0, 0, 0, 0);
		repeat (5) @(negedge core_clk);
		chk("boost", 3'b010, {charge_en, boost_en, hiz_active});
		$display("test host mode done");
	endtask : t_host

	// Clock enable low freezes the pulse timer, so the pulse is stretched
	task automatic t_freeze;
		@(posedge core_clk);
		bat_ovp <= 1'b1;
		wait_lvl(2, 1'b1, 10);
		chk("bat ovp boost", 1'b0, boost_en);
		@(posedge core_clk);
		ce <= 1'b0;
		repeat (4) @(posedge core_clk);
		ce <= 1'b1;
		wait_lvl(2, 1'b0, 100);
		// One counted edge before the freeze, so PC-1 more after it plus one to see it low
		chk("frozen pulse width", PC, n);
		@(posedge core_clk);
		bat_ovp <= 1'b0;
		$display("test clock enable done");
	endtask : t_freeze

	// Main sequence
	initial
	begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset();
		t_good();
		t_dpm_sleep();
		t_ovp();
		t_bad();
		t_host();
		t_freeze();
		tally_and_finish();
	end
endmodule : cps_top_tb
